// *** tb/tv_encoder_ctrl_properties.sv ***
/*
  Concurrent checks on the control bank.
  Assumes it is bound to the bank, seeing only its ports.
*/
`default_nettype none
module tv_encoder_ctrl_checker
  import tv_encoder_pkg::*;
#(
  parameter int LINE_PIXELS = 800
)(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       hsyncPinOut,
  input wire logic       hsyncPinOe,
  input wire logic       vsyncPinOut,
  input wire logic       vsyncPinOe,
  input wire logic       hsyncActive,
  input wire logic       vsyncActive,
  input wire logic       pixValid,
  input wire logic       dacRgbSelect,
  input wire logic       compositeSyncPinOe,
  input wire logic       coreEnable,
  input wire logic       coreResetN,
  input wire logic       senseCurrentEn,
  input wire logic       detectValid
);
  logic [3:0]  syncShadow;
  logic [11:0] hCnt;
  logic [11:0] vCnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ********************************
  // helper: sync shadow, pixels per pulse
  // ********************************
  always_ff @(posedge mclk) begin
    if (!rstn || !coreResetN) begin
      syncShadow <= 4'h0;
    end else if (regWrite && regAddr == SYNC_CONTROL_ADDR) begin
      syncShadow <= regWrData[3:0];
    end
    hCnt <= hsyncActive ? hCnt + {11'h000, pixValid} : 12'h000;
    vCnt <= vsyncActive ? vCnt + {11'h000, pixValid} : 12'h000;
  end

  // ********************************
  // properties
  // ********************************
  // polarity judged once the setting has settled
  property p_hpol;
    hsyncPinOe && syncShadow == $past(syncShadow, 2) |-> hsyncPinOut == ~(hsyncActive ^ syncShadow[0]);
  endproperty
  a_hpol: assert property (p_hpol) else $error("hsync polarity");
  property p_vpol;
    vsyncPinOe && syncShadow == $past(syncShadow, 2) |-> vsyncPinOut == ~(vsyncActive ^ syncShadow[1]);
  endproperty
  a_vpol: assert property (p_vpol) else $error("vsync polarity");
  property p_dir_in;
    !syncShadow[2] && !$past(syncShadow[2]) |-> !hsyncPinOe && !vsyncPinOe;
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("sync driven as input");
  property p_dir_out;
    syncShadow[2] && $past(syncShadow[2], 2) && coreEnable && $past(coreEnable) |-> hsyncPinOe && vsyncPinOe;
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("sync not driven");
  // a pulse cut by leaving output mode is not judged
  property p_hwidth;
    $fell(hsyncActive) && syncShadow[2] && $past(syncShadow[2], 2) |-> hCnt == 12'h040;
  endproperty
  a_hwidth: assert property (p_hwidth) else $error("hsync width");
  property p_vwidth;
    $fell(vsyncActive) && syncShadow[2] && $past(syncShadow[2], 2) |-> vCnt == 12'(2 * LINE_PIXELS);
  endproperty
  a_vwidth: assert property (p_vwidth) else $error("vsync length");
  property p_sense_quiet;
    senseCurrentEn && $past(senseCurrentEn) |-> !hsyncActive && !vsyncActive;
  endproperty
  a_sense_quiet: assert property (p_sense_quiet) else $error("sync while sensing");
  property p_soft_reset;
    regWrite && regAddr == POWER_CONTROL_ADDR && !regWrData[SOFT_RESET_N_BIT] |-> ##1 !coreResetN ##[0:1] !coreEnable;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("no soft reset");
  property p_detect;
    $rose(detectValid) |-> $past(regWrite && regAddr == CONNECTION_DETECT_ADDR && !regWrData[SENSE_BIT] && senseCurrentEn);
  endproperty
  a_detect: assert property (p_detect) else $error("valid without sense");
  property p_composite_sync_pin;
    $past(coreEnable && dacRgbSelect) == (coreEnable && dacRgbSelect) |-> compositeSyncPinOe == (coreEnable && dacRgbSelect);
  endproperty
  a_composite_sync_pin: assert property (p_composite_sync_pin) else $error("composite_sync_pin enable");
endmodule

bind tv_encoder_sync_power_detect_ctrl tv_encoder_ctrl_checker #(.LINE_PIXELS(LINE_PIXELS)) tv_encoder_ctrl_checker_i (.*);
`default_nettype wire

// *** tb/tv_encoder_sync_power_detect_ctrl_bench.sv ***
/*
  Self-checking bench of the control bank.
  Assumes the bank's package and the bound checker are compiled first.
*/
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tv_encoder_sync_power_detect_ctrl_bench
  import tv_encoder_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk, rstn, regWrite, regRead, pixValid, hsyncPinIn, vsyncPinIn, rdSeen;
  logic       lumaCmpAbove, chromaCmpAbove, compositeCmpAbove;
  logic [7:0] regAddr, regWrData, lumaIn, regRdData, lumaOut;
  logic       hsyncPinOut, hsyncPinOe, vsyncPinOut, vsyncPinOe, hsyncActive, vsyncActive;
  logic       lumaOutValid, dacRgbSelect, compositeSyncPinOut, compositeSyncPinOe;
  logic       lumaDacEn, chromaDacEn, compositeDacEn, coreEnable, bandgapEn, bufClkEn;
  logic       bufClkLimited, coreResetN, senseCurrentEn, detectValid;
  logic [7:0] rdQ[$], lumaQ[$];
  int         err_total = 0, compares = 0, cycles = 0, ce = 3;
  int         num[8] = '{5, 9, 17, 1, 17, 9, 5, 3};
  int         den[8] = '{4, 8, 16, 1, 16, 8, 4, 2};
  int         off[8] = '{102, 57, 30, 0, 0, 0, 0, 0};

  // short lines keep frames short
  tv_encoder_sync_power_detect_ctrl #(.LINE_PIXELS(80), .FRAME_LINES(4))
    tv_encoder_sync_power_detect_ctrl_i (.*);

  // ********************************
  // helpers
  // ********************************
  function automatic logic [7:0] lumaExp(input int s, input int y);
    int v;
    v = ((y - off[s]) * num[s]) / den[s];
    return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    rdQ.push_back(e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
  endtask
  task automatic pix(input logic [7:0] y);
    @(posedge mclk);
    lumaQ.push_back(lumaExp(ce, y));
    lumaIn <= y;
    pixValid <= 1'b1;
    @(posedge mclk);
    pixValid <= 1'b0;
  endtask
  // look mid-cycle, clear of the edge
  task automatic look();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ********************************
  // clock, watchdog and result monitor
  // ********************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    rdSeen <= regRead;
    if (rdSeen) `CHK(regRdData, rdQ.pop_front())
    if (lumaOutValid === 1'b1) `CHK(lumaOut, lumaQ.pop_front())
    if (cycles == 40000) begin
      err_total++;
      results();
    end
  end

  // ********************************
  // main sequence
  // ********************************
  initial begin
    {rstn, regWrite, regRead, pixValid, regAddr, regWrData, lumaIn} = '0;
    {hsyncPinIn, vsyncPinIn, lumaCmpAbove, chromaCmpAbove, compositeCmpAbove} = 5'h18;
    void'($urandom(79457));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    rd(SYNC_CONTROL_ADDR, SYNC_CONTROL_RESET);
    rd(POWER_CONTROL_ADDR, {3'h0, POWER_CONTROL_RESET});
    rd(CONNECTION_DETECT_ADDR, 8'h00);
    rd(CONTRAST_CONTROL_ADDR, {5'h00, CONTRAST_CONTROL_RESET});
    rd(8'h0f, 8'h00);
    // generated sync over two frames; checker judges widths
    wr(SYNC_CONTROL_ADDR, 8'h04);
    repeat (700) pix(8'($urandom));
    `CHK(hsyncPinOe, 1'b1)
    // pin input, every polarity
    for (int p = 0; p < 4; p++) begin
      wr(SYNC_CONTROL_ADDR, 8'(p));
      hsyncPinIn <= p[0];
      vsyncPinIn <= p[1];
      look();
      `CHK({hsyncActive, vsyncActive}, 2'b11)
      @(posedge mclk);
      hsyncPinIn <= ~p[0];
      vsyncPinIn <= ~p[1];
      look();
      `CHK({hsyncActive, vsyncActive}, 2'b00)
    end
    // embedded codes
    wr(SYNC_CONTROL_ADDR, 8'h08);
    foreach (num[i]) begin
      pix(CODE_PREAMBLE_HI);
      pix(CODE_PREAMBLE_LO);
      pix(CODE_PREAMBLE_LO);
      pix(8'(i << 4));
      look();
      `CHK({vsyncActive, hsyncActive}, 2'(i))
    end
    wr(SYNC_CONTROL_ADDR, 8'h00);
    // every contrast setting
    for (int s = 0; s < 8; s++) begin
      wr(CONTRAST_CONTROL_ADDR, 8'(s));
      ce = s;
      rd(CONTRAST_CONTROL_ADDR, 8'(s));
      pix(8'h00);
      pix(8'hff);
      pix(8'(off[s]));
      repeat (5) pix(8'($urandom));
    end
    // every power state
    for (int p = 0; p < 8; p++) begin
      wr(POWER_CONTROL_ADDR, 8'(8 + p));
      look();
      `CHK(lumaDacEn, 1'(p == 3 || p == 0))
      `CHK(chromaDacEn, 1'(p == 3 || p == 0))
      `CHK(compositeDacEn, 1'(p == 3 || p == 2))
      `CHK({bandgapEn, bufClkEn}, {2{1'(p < 4)}})
      `CHK({coreEnable, bufClkLimited}, {1'(p != 1 && p < 4), 1'(p == 1)})
    end
    wr(POWER_CONTROL_ADDR, 8'h1b);
    look();
    `CHK({dacRgbSelect, compositeSyncPinOe, compositeSyncPinOut}, 3'b110)
    // soft reset: other writes lost, reset values back
    wr(CONTRAST_CONTROL_ADDR, 8'h05);
    wr(POWER_CONTROL_ADDR, 8'h03);
    wr(CONTRAST_CONTROL_ADDR, 8'h06);
    look();
    `CHK({coreResetN, coreEnable}, 2'b00)
    wr(POWER_CONTROL_ADDR, 8'h0b);
    look();
    `CHK({coreResetN, dacRgbSelect}, 2'b10)
    rd(CONTRAST_CONTROL_ADDR, {5'h00, CONTRAST_CONTROL_RESET});
    ce = 3;
    // sensing with random loads
    for (int k = 0; k < 4; k++) begin
      {lumaCmpAbove, chromaCmpAbove, compositeCmpAbove} <= 3'($urandom);
      wr(CONNECTION_DETECT_ADDR, 8'h01);
      look();
      `CHK(senseCurrentEn, 1'b1)
      `CHK(detectValid, 1'(k > 0))
      wr(CONNECTION_DETECT_ADDR, 8'h00);
      rd(CONNECTION_DETECT_ADDR, {4'h0, lumaCmpAbove, chromaCmpAbove, compositeCmpAbove, 1'b0});
      `CHK({detectValid, senseCurrentEn}, 2'b10)
    end
    // clear without set must not resample
    {lumaCmpAbove, chromaCmpAbove, compositeCmpAbove} <= ~{lumaCmpAbove, chromaCmpAbove, compositeCmpAbove};
    look();
    wr(CONNECTION_DETECT_ADDR, 8'h00);
    rd(CONNECTION_DETECT_ADDR, {4'h0, ~{lumaCmpAbove, chromaCmpAbove, compositeCmpAbove}, 1'b0});
    repeat (4) @(posedge mclk);
    results();
  end
endmodule
`undef CHK
`default_nettype wire

// *** verilog/luma_contrast.sv ***
/*
  Combinational luma contrast stage: offset, rational gain, saturation.
  Assumes the caller registers the result on the pixel enable.
*/
`default_nettype none
module luma_contrast
  import tv_encoder_pkg::*;
(
  input  wire logic [2:0] setting,
  input  wire logic [7:0] lumaIn,
  output logic      [7:0] lumaOut
);

  // ************************************************************
  // gain table and arithmetic
  // ************************************************************
  logic        [6:0]  offset;
  logic        [4:0]  mul;
  logic        [2:0]  shift;
  logic signed [15:0] diff;
  logic signed [15:0] prod;
  logic signed [15:0] scaled;

  // select offset and gain for the setting
  always_comb begin
    unique case (setting)
      3'h0: begin offset = CE_OFFSET_0; mul = CE_MUL_5_4;   shift = 3'h2; end // RULE_19
      3'h1: begin offset = CE_OFFSET_1; mul = CE_MUL_9_8;   shift = 3'h3; end // RULE_19
      3'h2: begin offset = CE_OFFSET_2; mul = CE_MUL_17_16; shift = 3'h4; end // RULE_19
      3'h3: begin offset = 7'h00;       mul = CE_MUL_1;     shift = 3'h0; end // RULE_20
      3'h4: begin offset = 7'h00;       mul = CE_MUL_17_16; shift = 3'h4; end // RULE_20
      3'h5: begin offset = 7'h00;       mul = CE_MUL_9_8;   shift = 3'h3; end // RULE_20
      3'h6: begin offset = 7'h00;       mul = CE_MUL_5_4;   shift = 3'h2; end // RULE_20
      3'h7: begin offset = 7'h00;       mul = CE_MUL_3_2;   shift = 3'h1; end // RULE_20
    endcase
  end

  // signed arithmetic, shift floors negatives which clamp to zero anyway
  always_comb begin
    diff   = $signed({8'h00, lumaIn}) - $signed({9'h000, offset});
    prod   = 16'(diff * $signed({11'h000, mul}));
    scaled = prod >>> shift;
    if (scaled < 16'sd0) begin
      lumaOut = 8'h00; // RULE_21
    end else if (scaled > 16'sd255) begin
      lumaOut = 8'hff; // RULE_21
    end else begin
      lumaOut = scaled[7:0];
    end
  end

endmodule
`default_nettype wire

// *** verilog/tv_encoder_pkg.sv ***
/*
  Shared constants of the encoder control bank: register offsets, field
  positions, reset values, sync timing and contrast table entries.
  Assumes a single 20 MHz mclk domain and an 8-bit register port.
*/
`default_nettype none
package tv_encoder_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] SYNC_CONTROL_ADDR      = 8'h0d;
  localparam logic [7:0] POWER_CONTROL_ADDR     = 8'h0e;
  localparam logic [7:0] CONNECTION_DETECT_ADDR = 8'h10;
  localparam logic [7:0] CONTRAST_CONTROL_ADDR  = 8'h11;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int HSYNC_POLARITY_BIT   = 0;
  localparam int VSYNC_POLARITY_BIT   = 1;
  localparam int SYNC_DIRECTION_BIT   = 2;
  localparam int EMBEDDED_SYNC_BIT    = 3;
  localparam int POWER_STATE_MSB      = 2;
  localparam int SOFT_RESET_N_BIT     = 3;
  localparam int RGB_OUTPUT_BIT       = 4;
  localparam int SENSE_BIT            = 0;
  localparam int COMPOSITE_STATUS_BIT = 1;
  localparam int CHROMA_STATUS_BIT    = 2;
  localparam int LUMA_STATUS_BIT      = 3;
  localparam int EMB_H_BIT            = 4;
  localparam int EMB_V_BIT            = 5;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [3:0] SYNC_CONTROL_RESET     = 4'h0;
  localparam logic [4:0] POWER_CONTROL_RESET    = 5'h0b;
  localparam logic [2:0] CONTRAST_CONTROL_RESET = 3'h3;
  localparam logic [2:0] DETECT_STATUS_RESET    = 3'h0;

  // ************************************************************
  // power states
  // ************************************************************
  localparam logic [2:0] PWR_COMPOSITE_OFF = 3'h0;
  localparam logic [2:0] PWR_POWER_DOWN    = 3'h1;
  localparam logic [2:0] PWR_SVIDEO_OFF    = 3'h2;
  localparam logic [2:0] PWR_NORMAL        = 3'h3;

  // ************************************************************
  // sync timing and embedded code bytes
  // ************************************************************
  localparam int         CNT_W          = 12;
  localparam logic [11:0] HSYNC_PIXELS  = 12'h040;
  localparam logic [11:0] VSYNC_LINES   = 12'h002;
  localparam logic [7:0] CODE_PREAMBLE_HI = 8'hff;
  localparam logic [7:0] CODE_PREAMBLE_LO = 8'h00;

  // ************************************************************
  // contrast table: offset and multiplier entries; the shift per setting sits in luma_contrast
  // ************************************************************
  localparam logic [6:0] CE_OFFSET_0 = 7'h66;
  localparam logic [6:0] CE_OFFSET_1 = 7'h39;
  localparam logic [6:0] CE_OFFSET_2 = 7'h1e;
  localparam logic [4:0] CE_MUL_5_4  = 5'h05;
  localparam logic [4:0] CE_MUL_9_8  = 5'h09;
  localparam logic [4:0] CE_MUL_17_16 = 5'h11;
  localparam logic [4:0] CE_MUL_3_2  = 5'h03;
  localparam logic [4:0] CE_MUL_1    = 5'h01;

endpackage
`default_nettype wire

// *** verilog/tv_encoder_sync_power_detect_ctrl.sv ***
/*
  Sync, power, connection detect and contrast control bank of the encoder.
  Assumes the serial control port decodes transfers into a one-cycle
  register write strobe and read strobe on mclk; sync pins and the DAC
  comparators are asynchronous and are synchronised here.
*/
`default_nettype none

// What this block does
// RULE_01: horizontal sync polarity bit 0: clear active low, set active high.
// RULE_02: vertical sync polarity bit 1: clear active low, set active high.
// RULE_03: direction bit 2: clear syncs are inputs, set both are driven.
// RULE_04: bit 3 takes sync from pins or from codes embedded in luma stream.
// RULE_05: generated sync: horizontal pulse 64 pixels, vertical pulse 2 lines.
// RULE_06: power state 000 turns off only the composite DAC.
// RULE_07: power state 001 keeps only bandgap and restricted buffered clock.
// RULE_08: power state 010 turns off both luma/chroma DACs.
// RULE_09: power state 011 is normal, everything on, the reset default.
// RULE_10: power state msb set powers all down except serial port.
// RULE_11: soft reset bit low resets everything except itself and serial port; DAC enables here follow the power state, core/bandgap/buf clk off.
// RULE_12: software writes soft reset bit back to one to resume.
// RULE_13: RGB bit selects RGB DAC outputs and drives composite sync pin.
// RULE_14: connection status counts as invalid until one sense sequence completes.
// RULE_15: software sets normal power state before sensing.
// RULE_16: sense high drives constant DAC current and suppresses all sync.
// RULE_17: sense falling edge latches unconnected comparator results into status.
// RULE_18: status zero means connected load, one means unconnected output.
// RULE_19: settings 0-2 apply offset then gains 5/4, 9/8, 17/16.
// RULE_20: setting 3 passes luma; 4-7 gain 17/16, 9/8, 5/4, 3/2.
// RULE_21: contrast result saturates to 0 through 255.
// RULE_22: status holds until next sense falling edge or reset to zero.
module tv_encoder_sync_power_detect_ctrl
  import tv_encoder_pkg::*;
#(
  parameter int LINE_PIXELS = 800,
  parameter int FRAME_LINES = 525
)(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       hsyncPinIn,
  input  wire logic       vsyncPinIn,
  output logic            hsyncPinOut,
  output logic            hsyncPinOe,
  output logic            vsyncPinOut,
  output logic            vsyncPinOe,
  output logic            hsyncActive,
  output logic            vsyncActive,
  input  wire logic       pixValid,
  input  wire logic [7:0] lumaIn,
  output logic      [7:0] lumaOut,
  output logic            lumaOutValid,
  output logic            dacRgbSelect,
  output logic            compositeSyncPinOut,
  output logic            compositeSyncPinOe,
  output logic            lumaDacEn,
  output logic            chromaDacEn,
  output logic            compositeDacEn,
  output logic            coreEnable,
  output logic            bandgapEn,
  output logic            bufClkEn,
  output logic            bufClkLimited,
  output logic            coreResetN,
  output logic            senseCurrentEn,
  input  wire logic       lumaCmpAbove,
  input  wire logic       chromaCmpAbove,
  input  wire logic       compositeCmpAbove,
  output logic            detectValid
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (LINE_PIXELS <= 64 || LINE_PIXELS > 4096) begin : g_bad_line
    $error("LINE_PIXELS must be 65..4096");
  end
  if (FRAME_LINES <= 2 || FRAME_LINES > 4096) begin : g_bad_frame
    $error("FRAME_LINES must be 3..4096");
  end

  localparam logic [11:0] LAST_PIXEL = 12'(LINE_PIXELS - 1);
  localparam logic [11:0] LAST_LINE  = 12'(FRAME_LINES - 1);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [3:0]       syncControl;
    logic [4:0]       powerControl;
    logic [2:0]       contrastControl;
    logic             sense;
    logic [2:0]       detectStatus;
    logic             detectValid;
    logic [7:0]       rdData;
    logic             hsMeta;
    logic             hsPin;
    logic             vsMeta;
    logic             vsPin;
    logic [2:0]       cmpMeta;
    logic [2:0]       cmpPin;
    logic [CNT_W-1:0] pixCount;
    logic [CNT_W-1:0] lineCount;
    logic [1:0]       codeCount;
    logic             embH;
    logic             embV;
    logic             hsAct;
    logic             vsAct;
    logic             hsOut;
    logic             hsOe;
    logic             vsOut;
    logic             vsOe;
    logic             csOut;
    logic             csOe;
    logic [7:0]       lumaOut;
    logic             lumaValid;
    logic [5:0]       pwrEn;
    logic             bufLimited;
  } state_s;

  state_s s;
  state_s next_s;
  logic [7:0] contrastResult;

  // ************************************************************
  // functions
  // ************************************************************
  function automatic state_s resetState();
    state_s r;
    r                 = '0;
    r.syncControl     = SYNC_CONTROL_RESET;
    r.powerControl    = POWER_CONTROL_RESET;
    r.contrastControl = CONTRAST_CONTROL_RESET;
    r.detectStatus    = DETECT_STATUS_RESET;
    r.pwrEn           = 6'h3f;
    r.hsOut           = 1'b1;
    r.vsOut           = 1'b1;
    r.csOut           = 1'b1;
    return r;
  endfunction

  // pin level from logical sync and polarity, and back: same relation
  function automatic logic syncLevel(input logic a, input logic pol);
    return ~(a ^ pol);
  endfunction

  // enables: {luma dac, chroma dac, composite dac, core, bandgap, buf clk}
  function automatic logic [5:0] powerDecode(input logic [2:0] st);
    logic [5:0] e;
    e = 6'h00; // RULE_10
    if (!st[POWER_STATE_MSB]) begin
      unique case (st)
        PWR_COMPOSITE_OFF: e = 6'h37; // RULE_06
        PWR_POWER_DOWN:    e = 6'h03; // RULE_07
        PWR_SVIDEO_OFF:    e = 6'h0f; // RULE_08
        PWR_NORMAL:        e = 6'h3f; // RULE_09
        default:           e = 6'h00;
      endcase
    end
    return e;
  endfunction

  // ************************************************************
  // contrast stage
  // ************************************************************
  luma_contrast luma_contrast_i (
    .setting (s.contrastControl),
    .lumaIn  (lumaIn),
    .lumaOut (contrastResult)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic core;
    logic genH;
    logic genV;
    logic srcH;
    logic srcV;
    logic [2:0] readNow;
    core = s.pwrEn[2];
    genH = 1'b0;
    genV = 1'b0;
    srcH = 1'b0;
    srcV = 1'b0;
    readNow = 3'h0;
    next_s = s;

    // pin and comparator synchronisers
    next_s.hsMeta  = hsyncPinIn;
    next_s.hsPin   = s.hsMeta;
    next_s.vsMeta  = vsyncPinIn;
    next_s.vsPin   = s.vsMeta;
    next_s.cmpMeta = {lumaCmpAbove, chromaCmpAbove, compositeCmpAbove};
    next_s.cmpPin  = s.cmpMeta;

    // register writes
    if (regWrite) begin
      unique case (regAddr)
        SYNC_CONTROL_ADDR:      next_s.syncControl = regWrData[3:0];
        POWER_CONTROL_ADDR:     next_s.powerControl = regWrData[4:0];
        CONTRAST_CONTROL_ADDR:  next_s.contrastControl = regWrData[2:0];
        CONNECTION_DETECT_ADDR: begin
          next_s.sense = regWrData[SENSE_BIT];
          // falling edge of sense samples the comparators
          if (s.sense && !regWrData[SENSE_BIT]) begin
            next_s.detectStatus = s.cmpPin; // RULE_17 RULE_18 RULE_22
            next_s.detectValid  = 1'b1;     // RULE_14
          end
        end
        default: ;
      endcase
    end

    // read port, sense reads back as zero since it is write only
    if (regRead) begin
      unique case (regAddr)
        SYNC_CONTROL_ADDR:      next_s.rdData = {4'h0, s.syncControl};
        POWER_CONTROL_ADDR:     next_s.rdData = {3'h0, s.powerControl};
        CONTRAST_CONTROL_ADDR:  next_s.rdData = {5'h00, s.contrastControl};
        CONNECTION_DETECT_ADDR: next_s.rdData = {4'h0, s.detectStatus, 1'b0};
        default:                next_s.rdData = 8'h00;
      endcase
    end

    // free-running timing generator for driven sync
    if (pixValid && core) begin
      if (s.pixCount == LAST_PIXEL) begin
        next_s.pixCount = '0;
        next_s.lineCount = (s.lineCount == LAST_LINE) ? '0 : s.lineCount + 12'h001;
      end else begin
        next_s.pixCount = s.pixCount + 12'h001;
      end
    end
    genH = s.pixCount < HSYNC_PIXELS; // RULE_05
    genV = s.lineCount < VSYNC_LINES; // RULE_05

    // embedded code search: preamble hi, lo, lo, then flag byte
    if (pixValid) begin
      if (s.codeCount == 2'h3) begin
        next_s.embH = lumaIn[EMB_H_BIT];
        next_s.embV = lumaIn[EMB_V_BIT];
        next_s.codeCount = 2'h0;
      end else if (lumaIn == CODE_PREAMBLE_HI) begin
        next_s.codeCount = 2'h1;
      end else if (lumaIn == CODE_PREAMBLE_LO && s.codeCount != 2'h0) begin
        next_s.codeCount = s.codeCount + 2'h1;
      end else begin
        next_s.codeCount = 2'h0;
      end
    end

    // choose sync source
    if (s.syncControl[SYNC_DIRECTION_BIT]) begin
      srcH = genH; // RULE_03
      srcV = genV;
    end else if (s.syncControl[EMBEDDED_SYNC_BIT]) begin
      srcH = s.embH; // RULE_04
      srcV = s.embV;
    end else begin
      srcH = syncLevel(s.hsPin, s.syncControl[HSYNC_POLARITY_BIT]); // RULE_01 RULE_04
      srcV = syncLevel(s.vsPin, s.syncControl[VSYNC_POLARITY_BIT]); // RULE_02
    end

    // sense mode keeps the outputs steady: no sync at all
    next_s.hsAct = srcH && core && !s.sense; // RULE_16
    next_s.vsAct = srcV && core && !s.sense; // RULE_16
    next_s.hsOut = syncLevel(next_s.hsAct, s.syncControl[HSYNC_POLARITY_BIT]); // RULE_01
    next_s.vsOut = syncLevel(next_s.vsAct, s.syncControl[VSYNC_POLARITY_BIT]); // RULE_02
    next_s.hsOe  = s.syncControl[SYNC_DIRECTION_BIT] && core; // RULE_03
    next_s.vsOe  = s.syncControl[SYNC_DIRECTION_BIT] && core; // RULE_03

    // composite sync, active low, only in RGB mode
    next_s.csOut = ~(next_s.hsAct | next_s.vsAct);
    next_s.csOe  = s.powerControl[RGB_OUTPUT_BIT] && core; // RULE_13

    // luma path registered on the pixel enable
    next_s.lumaValid = pixValid && core;
    if (pixValid && core) begin
      next_s.lumaOut = contrastResult;
    end

    // power enables
    next_s.pwrEn      = powerDecode(s.powerControl[POWER_STATE_MSB:0]);
    next_s.bufLimited = s.powerControl[POWER_STATE_MSB:0] == PWR_POWER_DOWN; // RULE_07

    // soft reset: everything but its own bit, the read port state and the DAC enables, which follow the power state; core, bandgap, buf clk off
    if (!s.powerControl[SOFT_RESET_N_BIT]) begin
      readNow = next_s.pwrEn[5:3];
      next_s  = resetState(); // RULE_11
      next_s.powerControl[SOFT_RESET_N_BIT] = regWrite && regAddr == POWER_CONTROL_ADDR
        && regWrData[SOFT_RESET_N_BIT]; // RULE_12
      next_s.rdData = regRead ? ((regAddr == POWER_CONTROL_ADDR) ?
        {3'h0, s.powerControl} : 8'h00) : s.rdData;
      next_s.pwrEn = {readNow, 3'h0};
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= resetState();
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs, all taken from the state register
  // ************************************************************
  assign regRdData           = s.rdData;
  assign hsyncPinOut         = s.hsOut;
  assign hsyncPinOe          = s.hsOe;
  assign vsyncPinOut         = s.vsOut;
  assign vsyncPinOe          = s.vsOe;
  assign hsyncActive         = s.hsAct;
  assign vsyncActive         = s.vsAct;
  assign lumaOut             = s.lumaOut;
  assign lumaOutValid        = s.lumaValid;
  assign dacRgbSelect        = s.powerControl[RGB_OUTPUT_BIT]; // RULE_13
  assign compositeSyncPinOut = s.csOut;
  assign compositeSyncPinOe  = s.csOe;
  assign lumaDacEn           = s.pwrEn[5];
  assign chromaDacEn         = s.pwrEn[4];
  assign compositeDacEn      = s.pwrEn[3];
  assign coreEnable          = s.pwrEn[2];
  assign bandgapEn           = s.pwrEn[1];
  assign bufClkEn            = s.pwrEn[0];
  assign bufClkLimited       = s.bufLimited;
  assign coreResetN          = s.powerControl[SOFT_RESET_N_BIT];
  assign senseCurrentEn      = s.sense; // RULE_16
  assign detectValid         = s.detectValid; // RULE_14

endmodule
`default_nettype wire
